// file: rtl/ndisf_die_fsm.v
// die state machine: idle sub-states, idle read and status handling
`timescale 1ns/1ps
`include "ndisf_regs.vh"
module ndisf_die_fsm
(
  input wire clock,
  input wire rst,
  input wire req_ilv_out,
  input wire req_clear_pg,
  input wire req_invalid_pg,
  input wire req_rd_pp,
  input wire req_rd_uid,
  input wire req_status,
  input wire req_status_value,
  input wire ind_78h,
  input wire ind_70h,
  input wire req_col_sel,
  input wire req_read,
  input wire cmd_valid,
  input wire [7:0] cmd_opcode,
  input wire [`NDISF_ILV_W-1:0] ilv_addr,
  input wire [`NDISF_COL_W-1:0] col_addr,
  input wire row_die_match,
  input wire bus_x16,
  input wire load_done,
  input wire bg_read_done,
  input wire [7:0] load_data,
  input wire load_we,
  input wire [`NDISF_COL_W-1:0] load_addr,
  input wire [7:0] confirm_opcode,
  input wire confirm_we,
  input wire [7:0] status_set,
  input wire status_we,
  input wire [`NDISF_NILV*2-1:0] fail_set,
  input wire fail_we,
  input wire ilv_active,
  output reg [15:0] data_out,
  output reg data_out_valid,
  output reg [7:0] status_out,
  output reg status_out_valid,
  output reg out_drive_en,
  output reg data_present,
  output reg page_valid,
  output reg to_cache_next,
  output reg to_cache_end,
  output reg to_target_request,
  output reg [`NDISF_ILV_W-1:0] output_interleave_sel,
  output reg [`NDISF_ILV_W-1:0] status_interleave_sel,
  output reg [7:0] last_status_opcode,
  output reg [7:0] die_status_reg,
  output reg [`NDISF_ST_W-1:0] state_reg
);

// =====================================================================
// states
localparam [`NDISF_ST_W-1:0] S_IDLE = 17'h0_0001;
localparam [`NDISF_ST_W-1:0] S_ILV_OUT = 17'h0_0002;
localparam [`NDISF_ST_W-1:0] S_CLR_PG = 17'h0_0004;
localparam [`NDISF_ST_W-1:0] S_INV_PG = 17'h0_0008;
localparam [`NDISF_ST_W-1:0] S_RD_PP = 17'h0_0010;
localparam [`NDISF_ST_W-1:0] S_RD_UID = 17'h0_0020;
localparam [`NDISF_ST_W-1:0] S_LOAD_END = 17'h0_0040;
localparam [`NDISF_ST_W-1:0] S_IDLE_RD = 17'h0_0080;
localparam [`NDISF_ST_W-1:0] S_RD_FINISH = 17'h0_0100;
localparam [`NDISF_ST_W-1:0] S_RD_XFER = 17'h0_0200;
localparam [`NDISF_ST_W-1:0] S_COL_SEL = 17'h0_0400;
localparam [`NDISF_ST_W-1:0] S_STAT_EXEC = 17'h0_0800;
localparam [`NDISF_ST_W-1:0] S_STAT_VALUE = 17'h0_1000;
localparam [`NDISF_ST_W-1:0] S_STAT_ENH = 17'h0_2000;
localparam [`NDISF_ST_W-1:0] S_STAT_LEGACY = 17'h0_4000;
localparam [`NDISF_ST_W-1:0] S_OFF_IDLE = 17'h0_8000;
// interleaved-program wait: owned by the program flow, here only a resume target
localparam [`NDISF_ST_W-1:0] S_PP_ILV_WAIT = 17'h1_0000;

// =====================================================================
// storage
reg [7:0] page_mem [0:`NDISF_PAGE_BYTES-1];
reg [`NDISF_ST_W-1:0] saved_return_state;
reg [`NDISF_ST_W-1:0] state_next;
reg [`NDISF_ST_W-1:0] ret_next;
reg [`NDISF_NILV*2-1:0] per_plane_fail_bits;
reg [7:0] last_confirm_opcode;
reg [`NDISF_COL_W-1:0] col_reg;
reg clr_busy_reg;
reg [`NDISF_COL_W-1:0] clr_addr_reg;
wire [1:0] fail_or;
wire [1:0] fail_sel;
wire [`NDISF_COL_W-1:0] col_plus1;
wire cmd_is_seq;
wire cmd_is_end;
wire cache_next_next;
wire cache_end_next;
wire tgt_req_next;
wire [7:0] rd_lo;
wire [7:0] rd_hi;

// =====================================================================
// functions
// or of each fail column across all interleave addresses
function [1:0] ndisf_fail_or;
  input [`NDISF_NILV*2-1:0] f;
  integer k;
  begin
    ndisf_fail_or = 2'b00;
    for (k = 0; k < `NDISF_NILV; k = k + 1)
      ndisf_fail_or = ndisf_fail_or | f[k*2 +: 2];
  end
endfunction

// opcode match on a live command cycle
function ndisf_cmd_hit;
  input valid;
  input [7:0] opcode;
  input [7:0] want;
  begin
    ndisf_cmd_hit = valid && (opcode == want);
  end
endfunction

// column pointer step; wraps at the page end
function [`NDISF_COL_W-1:0] ndisf_col_add;
  input [`NDISF_COL_W-1:0] col;
  input [1:0] step;
  begin
    ndisf_col_add = col + {{(`NDISF_COL_W-2){1'b0}}, step};
  end
endfunction

// a byte that a running clear has not yet swept already reads as ones
function [7:0] ndisf_page_byte;
  input [`NDISF_COL_W-1:0] addr;
  input [7:0] mem_byte;
  input sweeping;
  input [`NDISF_COL_W-1:0] sweep_addr;
  begin
    if (sweeping && (addr >= sweep_addr))
      ndisf_page_byte = 8'hff;
    else
      ndisf_page_byte = mem_byte;
  end
endfunction

// =====================================================================
// shared decode
assign fail_or = ndisf_fail_or(per_plane_fail_bits);
assign fail_sel = per_plane_fail_bits[status_interleave_sel*2 +: 2];
assign col_plus1 = ndisf_col_add(col_reg, 2'b01);
assign cmd_is_seq = ndisf_cmd_hit(cmd_valid, cmd_opcode, `NDISF_OPC_31);
assign cmd_is_end = ndisf_cmd_hit(cmd_valid, cmd_opcode, `NDISF_OPC_3F) && (last_confirm_opcode == `NDISF_OPC_31);
assign rd_lo = ndisf_page_byte(col_reg, page_mem[col_reg], clr_busy_reg, clr_addr_reg);
assign rd_hi = ndisf_page_byte(col_plus1, page_mem[col_plus1], clr_busy_reg, clr_addr_reg);

// =====================================================================
// next state
always @*
begin
  state_next = state_reg;
  ret_next = saved_return_state;
  case (state_reg)
    S_IDLE:
    begin
      ret_next = S_IDLE;
      if (req_status)
        state_next = S_STAT_EXEC;
      else if (req_ilv_out)
        state_next = S_ILV_OUT;
      else if (req_clear_pg)
        state_next = S_CLR_PG;
      else if (req_invalid_pg)
        state_next = S_INV_PG;
      else if (req_rd_pp)
        state_next = S_RD_PP;
      else if (req_rd_uid)
        state_next = S_RD_UID;
    end
    S_ILV_OUT, S_CLR_PG, S_INV_PG, S_STAT_LEGACY:
      state_next = saved_return_state;
    S_RD_PP, S_RD_UID:
    begin
      ret_next = state_reg;
      if (load_done)
        state_next = S_LOAD_END;
      else if (req_status)
        state_next = S_STAT_EXEC;
    end
    S_LOAD_END:
      state_next = S_IDLE_RD;
    S_IDLE_RD:
    begin
      ret_next = S_IDLE_RD;
      if (bg_read_done)
        state_next = S_RD_FINISH;
      else if (req_col_sel)
        state_next = S_COL_SEL;
      else if (req_read)
        state_next = S_RD_XFER;
      else if (cmd_is_seq)
        state_next = S_IDLE;
      else if (cmd_is_end)
        state_next = S_IDLE;
      else if (req_status)
        state_next = S_STAT_EXEC;
      else if (req_ilv_out || req_clear_pg || req_invalid_pg || req_rd_pp || req_rd_uid)
        state_next = S_IDLE;
    end
    S_RD_FINISH:
      state_next = S_IDLE_RD;
    S_RD_XFER, S_COL_SEL:
      state_next = (saved_return_state == S_PP_ILV_WAIT) ? S_PP_ILV_WAIT : S_IDLE_RD;
    S_STAT_EXEC:
    begin
      if (req_status_value)
        state_next = S_STAT_VALUE;
      else if (ind_78h)
        state_next = S_STAT_ENH;
      else if (ind_70h)
        state_next = S_STAT_LEGACY;
    end
    S_STAT_VALUE:
      state_next = saved_return_state;
    S_STAT_ENH:
    begin
      if (row_die_match)
        state_next = saved_return_state;
      else if (saved_return_state == S_IDLE_RD)
        state_next = S_OFF_IDLE;
      else
        state_next = saved_return_state;
    end
    S_OFF_IDLE:
      state_next = S_IDLE;
    S_PP_ILV_WAIT:
      state_next = S_PP_ILV_WAIT;
    default:
      state_next = S_IDLE;
  endcase
end

// =====================================================================
// pulse outputs
// each follows the arc actually taken, so a higher priority arc masks it
assign cache_next_next = (state_reg == S_IDLE_RD) && (state_next == S_IDLE) && cmd_is_seq;
assign cache_end_next = (state_reg == S_IDLE_RD) && (state_next == S_IDLE) && !cmd_is_seq && cmd_is_end;
assign tgt_req_next = (state_reg == S_IDLE_RD) && (state_next == S_IDLE) && !cmd_is_seq && !cmd_is_end;

// =====================================================================
// registers
always @(posedge clock or posedge rst)
begin
  if (rst)
  begin
    state_reg <= S_IDLE;
    saved_return_state <= S_IDLE;
    die_status_reg <= `NDISF_STATUS_RST;
    last_status_opcode <= `NDISF_OPC_70;
    last_confirm_opcode <= `NDISF_CONFIRM_RST;
    per_plane_fail_bits <= {(`NDISF_NILV*2){1'b0}};
    output_interleave_sel <= {`NDISF_ILV_W{1'b0}};
    status_interleave_sel <= {`NDISF_ILV_W{1'b0}};
    col_reg <= {`NDISF_COL_W{1'b0}};
    page_valid <= 1'b0;
    out_drive_en <= 1'b1;
    data_out <= 16'h0000;
    data_out_valid <= 1'b0;
    status_out <= 8'h00;
    status_out_valid <= 1'b0;
    data_present <= 1'b0;
    to_cache_next <= 1'b0;
    to_cache_end <= 1'b0;
    to_target_request <= 1'b0;
    clr_busy_reg <= 1'b0;
    clr_addr_reg <= {`NDISF_COL_W{1'b0}};
  end
  else
  begin
    state_reg <= state_next;
    saved_return_state <= ret_next;
    data_out_valid <= 1'b0;
    status_out_valid <= 1'b0;
    data_present <= 1'b0;
    to_cache_next <= cache_next_next;
    to_cache_end <= cache_end_next;
    to_target_request <= tgt_req_next;
    if (confirm_we)
      last_confirm_opcode <= confirm_opcode;
    if (fail_we)
      per_plane_fail_bits <= fail_set;
    if (status_we)
      die_status_reg <= status_set;
    // clear sweep, one byte a cycle
    if (clr_busy_reg)
    begin
      clr_addr_reg <= ndisf_col_add(clr_addr_reg, 2'b01);
      if (clr_addr_reg == `NDISF_COL_LAST)
        clr_busy_reg <= 1'b0;
    end
    case (state_reg)
      S_ILV_OUT:
        output_interleave_sel <= ilv_addr;
      S_CLR_PG:
      begin
        clr_busy_reg <= 1'b1;
        clr_addr_reg <= {`NDISF_COL_W{1'b0}};
        page_valid <= 1'b1;
      end
      S_INV_PG:
        page_valid <= 1'b0;
      S_RD_PP, S_RD_UID:
        page_valid <= 1'b0;
      S_LOAD_END:
      begin
        data_present <= 1'b1;
        page_valid <= 1'b1;
        col_reg <= {`NDISF_COL_W{1'b0}};
      end
      S_RD_FINISH:
        die_status_reg[`NDISF_SR_RDY_BIT] <= 1'b1;
      S_RD_XFER:
      begin
        data_out_valid <= 1'b1;
        if (bus_x16)
        begin
          data_out <= {rd_hi, rd_lo};
          col_reg <= ndisf_col_add(col_reg, 2'b10);
        end
        else
        begin
          data_out <= {8'h00, rd_lo};
          col_reg <= col_plus1;
        end
      end
      S_COL_SEL:
        col_reg <= col_addr;
      S_STAT_VALUE:
      begin
        status_out_valid <= 1'b1;
        if (!ilv_active)
          status_out <= die_status_reg;
        else if (last_status_opcode == `NDISF_OPC_70)
          status_out <= {die_status_reg[7:2], fail_or};
        else
          status_out <= {die_status_reg[7:2], fail_sel};
      end
      S_STAT_ENH:
      begin
        if (row_die_match)
        begin
          last_status_opcode <= `NDISF_OPC_78;
          status_interleave_sel <= ilv_addr;
          out_drive_en <= 1'b1;
        end
        else
          out_drive_en <= 1'b0;
      end
      S_STAT_LEGACY:
        last_status_opcode <= `NDISF_OPC_70;
      default:
      begin
      end
    endcase
  end
end

// =====================================================================
// page array
// no reset on the array; loader writes are dropped while a clear sweep runs
always @(posedge clock)
begin
  if (clr_busy_reg)
    page_mem[clr_addr_reg] <= 8'hff;
  else if (load_we)
    page_mem[load_addr] <= load_data;
end

endmodule

// file: rtl/ndisf_regs.vh
// constants for the die idle, idle-read and status state machine
//
// Behaviour
// - store data-out interleave address, resume saved state
// - clear fills ones, invalidate marks invalid
// - parameter page load, busy until done
// - page load is saved state; status served
// - unique id load, saved state recorded
// - signal data present, then idle read
// - idle read sets saved state to itself
// - background read done sets status bit 5
// - read returns byte or word, column advances
// - column select positions page pointer
// - after transfer, go interleaved wait or idle read
// - 31h in idle read goes cache next
// - 3Fh goes cache end if last confirm 31h
// - status dispatch: value, enhanced, legacy
// - interleaved status bits: copy high, fail low
// - no interleave returns raw status, resume
// - enhanced status compares die select
// - selected: opcode 78h, store selector, output on
// - unselected: output off, idle or resume
// - legacy status records 70h, resume
// - status register powers up 00h
// - last status opcode powers up 70h
// - fail pair kept per interleave address
`ifndef NDISF_REGS_VH
`define NDISF_REGS_VH
`define NDISF_STATUS_RST 8'h00
`define NDISF_OPC_70 8'h70
`define NDISF_OPC_78 8'h78
`define NDISF_OPC_31 8'h31
`define NDISF_OPC_3F 8'h3f
`define NDISF_CONFIRM_RST 8'hff
`define NDISF_SR_RDY_BIT 5
`define NDISF_ILV_W 2
`define NDISF_NILV 4
`define NDISF_COL_W 12
`define NDISF_PAGE_BYTES 4096
`define NDISF_COL_LAST 12'hfff
`define NDISF_ST_W 17
`endif

// file: dv/ndisf_chk_properties.sv
// assertion checker for the die state machine
`timescale 1ns/1ps
module ndisf_chk
(
  input wire clock,
  input wire rst,
  input wire req_read,
  input wire row_die_match,
  input wire bg_read_done,
  input wire load_done,
  input wire status_we,
  input wire ilv_active,
  input wire data_out_valid,
  input wire [7:0] status_out,
  input wire status_out_valid,
  input wire out_drive_en,
  input wire data_present,
  input wire [7:0] last_status_opcode,
  input wire [7:0] die_status_reg
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ====
  // checks
  a_read_answer: assert property (data_out_valid |-> $past(req_read, 2))
    else $error("read data unrequested");
  a_raw_status: assert property (status_out_valid && !ilv_active |-> status_out == die_status_reg)
    else $error("raw status wrong");
  a_ilv_high_bits: assert property (status_out_valid |-> status_out[7:2] == die_status_reg[7:2])
    else $error("status high bits wrong");
  // bit 3 only separates 78h from 70h
  a_enh_record: assert property ($rose(last_status_opcode[3]) |-> out_drive_en && $past(row_die_match))
    else $error("78h recorded badly");
  a_unsel_off: assert property ($fell(out_drive_en) |-> !$past(row_die_match))
    else $error("output off while selected");
  a_data_present: assert property (data_present |-> $past(load_done, 2))
    else $error("data present early");
  a_ready_bit: assert property ($rose(die_status_reg[5]) |-> $past(bg_read_done, 2) || $past(status_we))
    else $error("bit 5 set unprompted");
  a_reset_vals: assert property (disable iff (1'b0) rst |-> last_status_opcode == 8'h70 && !die_status_reg)
    else $error("power-on values wrong");
  // ====
  // coverage
  cover property (status_out_valid && ilv_active);
  cover property ($fell(out_drive_en));
  cover property (data_present);
endmodule
bind ndisf_die_fsm ndisf_chk u_ndisf_chk (.clock, .rst, .req_read, .row_die_match, .bg_read_done, .load_done,
  .status_we, .ilv_active, .data_out_valid, .status_out, .status_out_valid, .out_drive_en, .data_present,
  .last_status_opcode, .die_status_reg);

// file: dv/ndisf_target_model.sv
// target-side model that loads page data into the die
`timescale 1ns/1ps
module ndisf_target_model
#(
  parameter NB = 8
)
(
  input wire clock,
  input wire rst,
  input wire req_load,
  input wire data_present,
  output reg load_we,
  output reg [11:0] load_addr,
  output reg [7:0] load_data,
  output reg load_done
);
  reg [4:0] cnt_reg;
  reg busy_reg;
  // ====
  // load sequencer
  // done is held until data shows present, since a status visit may hide it
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      {load_we, load_addr, load_data, load_done, cnt_reg, busy_reg} <= '0;
    else
    begin
      load_we <= 1'b0;
      load_data <= ~load_data;
      if (req_load)
      begin
        busy_reg <= 1'b1;
        cnt_reg <= 5'h00;
      end
      else if (busy_reg && cnt_reg < NB)
      begin
        load_we <= 1'b1;
        load_addr <= {7'h00, cnt_reg};
        load_data <= {3'h0, cnt_reg} ^ 8'h5a;
        cnt_reg <= cnt_reg + 5'h01;
      end
      else if (busy_reg)
      begin
        load_done <= !data_present;
        busy_reg <= !data_present;
      end
    end
  end
endmodule

// file: dv/testbench.sv
// self-checking bench for the die state machine
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
  $display("Error %0t got %h exp %h", $time, a, e); end end
module testbench;
  reg clock, rst, req_status, req_status_value, ind_78h, ind_70h, cmd_valid, row_die_match, bus_x16;
  reg confirm_we, status_we, fail_we, ilv_active;
  reg [7:0] rq, cmd_opcode, confirm_opcode, status_set, fail_set;
  reg [1:0] ilv_addr;
  reg [11:0] col_addr;
  wire [15:0] data_out;
  wire [7:0] status_out, last_status_opcode, die_status_reg, load_data;
  wire [11:0] load_addr;
  wire [1:0] output_interleave_sel, status_interleave_sel;
  wire data_out_valid, status_out_valid, out_drive_en, data_present, page_valid, to_cache_next, to_cache_end;
  wire load_we, load_done, to_target_request;
  logic [15:0] q[$];
  int fail_count, tests_run, pn, cn, en, tn, cyc;
  ndisf_die_fsm u_ndisf_die_fsm (.clock, .rst, .req_ilv_out(rq[0]), .req_clear_pg(rq[1]), .req_invalid_pg(rq[2]),
    .req_rd_pp(rq[3]), .req_rd_uid(rq[4]), .req_col_sel(rq[5]), .req_read(rq[6]), .bg_read_done(rq[7]),
    .req_status, .req_status_value, .ind_78h, .ind_70h, .cmd_valid, .cmd_opcode, .ilv_addr, .col_addr,
    .row_die_match, .bus_x16, .load_done, .load_data, .load_we, .load_addr, .confirm_opcode, .confirm_we,
    .status_set, .status_we, .fail_set, .fail_we, .ilv_active, .data_out, .data_out_valid, .status_out,
    .status_out_valid, .out_drive_en, .data_present, .page_valid, .to_cache_next, .to_cache_end,
    .to_target_request, .output_interleave_sel, .status_interleave_sel, .last_status_opcode,
    .die_status_reg, .state_reg());
  ndisf_target_model u_ndisf_target_model (.clock, .rst, .req_load(rq[3] | rq[4]), .data_present, .load_we,
    .load_addr, .load_data, .load_done);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ====
  // monitor and helpers
  always @(posedge clock)
  begin
    if (data_out_valid) q.push_back(data_out);
    if (status_out_valid) q.push_back({8'h00, status_out});
    pn += data_present;
    cn += to_cache_next;
    en += to_cache_end;
    tn += to_target_request;
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      end_of_test;
    end
  end
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task pulse(input [7:0] m);
    @(posedge clock);
    rq <= m;
    @(posedge clock);
    rq <= 8'h00;
    tick(3);
  endtask
  // k: 0 value, 1 enhanced, 2 legacy
  task stat(input int k);
    @(posedge clock);
    req_status <= 1'b1;
    @(posedge clock);
    req_status <= 1'b0;
    {req_status_value, ind_78h, ind_70h} <= 3'b100 >> k;
    @(posedge clock);
    {req_status_value, ind_78h, ind_70h} <= 3'b000;
    tick(5);
  endtask
  task cmd(input [7:0] op);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_opcode <= op;
    @(posedge clock);
    cmd_valid <= 1'b0;
    tick(3);
  endtask
  task take(input [15:0] e);
    logic [15:0] v;
    v = q.pop_front();
    `CHK(v, e)
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ====
  // tests
  initial
  begin
    {rq, req_status, req_status_value, ind_78h, ind_70h, cmd_valid, cmd_opcode, ilv_addr, col_addr} = 0;
    {bus_x16, confirm_opcode, confirm_we, status_set, status_we, fail_set, fail_we, ilv_active} = 0;
    row_die_match = 1'b1;
    #1 rst = 1'b1;
    tick(4);
    rst <= 1'b0;
    tick(1);
    `CHK(last_status_opcode, 8'h70)
    `CHK(die_status_reg, 8'h00)
    status_set <= 8'h4c;
    fail_set <= 8'h21;
    {status_we, fail_we} <= 2'b11;
    tick(1);
    {status_we, fail_we} <= 2'b00;
    stat(0);
    take(16'h004c);
    ilv_addr <= 2'h2;
    stat(1);
    `CHK({last_status_opcode, status_interleave_sel}, 10'h1e2)
    ilv_active <= 1'b1;
    stat(0);
    take(16'h004e);
    stat(2);
    `CHK(last_status_opcode, 8'h70)
    stat(0);
    take(16'h004f);
    ilv_active <= 1'b0;
    row_die_match <= 1'b0;
    stat(1);
    `CHK({out_drive_en, last_status_opcode}, 9'h070)
    row_die_match <= 1'b1;
    $display("status test done");
    ilv_addr <= 2'h3;
    pulse(8'h01);
    `CHK(output_interleave_sel, 2'h3)
    pulse(8'h08);
    stat(1);
    tick(20);
    `CHK({pn, last_status_opcode, page_valid}, {32'd1, 8'h78, 1'b1})
    col_addr <= 12'h001;
    pulse(8'h20);
    pulse(8'h40);
    pulse(8'h40);
    take(16'h005b);
    take(16'h0058);
    bus_x16 <= 1'b1;
    col_addr <= 12'h004;
    pulse(8'h20);
    pulse(8'h40);
    take(16'h5f5e);
    pulse(8'h80);
    `CHK(die_status_reg, 8'h6c)
    $display("read test done");
    cmd(8'h3f);
    cmd(8'h31);
    `CHK({cn, en}, {32'd1, 32'd0})
    pulse(8'h04);
    `CHK(page_valid, 1'b0)
    pulse(8'h02);
    tick(4200);
    bus_x16 <= 1'b0;
    pulse(8'h10);
    tick(20);
    `CHK(pn, 2)
    col_addr <= 12'h064;
    pulse(8'h20);
    pulse(8'h40);
    take(16'h00ff);
    pulse(8'h04);
    `CHK({tn, page_valid}, {32'd1, 1'b1})
    pulse(8'h10);
    tick(20);
    `CHK(pn, 3)
    confirm_opcode <= 8'h31;
    confirm_we <= 1'b1;
    tick(1);
    confirm_we <= 1'b0;
    cmd(8'h3f);
    `CHK(en, 1)
    $display("cache test done");
    end_of_test;
  end
endmodule
